//--- scg_pkg.sv
// scg_pkg: addresses, field positions, reset values and modes of the
// sleep clock gating block.
// assumes a 32-bit APB decode against the system control base address.
package scg_pkg;

    localparam logic [31:0] SCG_BASE_ADDR = 32'h400F_E000;
    localparam logic [11:0] SCG_SLEEP_GATE_OFS = 12'h114;
    localparam logic [11:0] SCG_GATE_STATUS_OFS = 12'h1F0;
    localparam logic [11:0] SCG_GATE_MODE_OFS = 12'h1F4;
    localparam logic [11:0] SCG_FAULT_STATUS_OFS = 12'h1F8;

    localparam logic [31:0] SCG_SLEEP_GATE_RST = 32'h0000_0000;
    // writable gate bits; every other bit is reserved, reads zero
    localparam logic [31:0] SCG_GATE_WMASK = 32'h030F_5037;

    localparam int SCG_COMPARATOR_B_BIT = 25;
    localparam int SCG_COMPARATOR_A_BIT = 24;
    localparam int SCG_GP_TIMER_D_BIT = 19;
    localparam int SCG_GP_TIMER_C_BIT = 18;
    localparam int SCG_GP_TIMER_B_BIT = 17;
    localparam int SCG_GP_TIMER_A_BIT = 16;
    localparam int SCG_TWO_WIRE_B_BIT = 14;
    localparam int SCG_TWO_WIRE_A_BIT = 12;
    localparam int SCG_SYNC_SERIAL_B_BIT = 5;
    localparam int SCG_SYNC_SERIAL_A_BIT = 4;
    localparam int SCG_ASYNC_SERIAL_C_BIT = 2;
    localparam int SCG_ASYNC_SERIAL_B_BIT = 1;
    localparam int SCG_ASYNC_SERIAL_A_BIT = 0;

    // fault status fields
    localparam int SCG_FLT_STICKY_BIT = 0;
    localparam int SCG_FLT_UNIT_LSB = 8;
    localparam int SCG_FLT_CNT_LSB = 16;
    localparam int SCG_FLT_CNT_MAX_W = 16;

    // gate mode fields
    localparam int SCG_MODE_AUTO_BIT = 2;
    localparam int SCG_MODE_DIFF_BIT = 3;

    typedef enum logic [1:0] {
        SCG_RUN,
        SCG_SLEEP,
        SCG_DEEP_SLEEP
    } scg_mode_t;

endpackage

//--- scg_gate_select.sv
// scg_gate_select: picks the gate vector that applies in the present
// power mode and registers it as the per-unit clock enables.
// assumes all gate vectors and the mode come from logic on i_clk_sys.
`timescale 1ns/10ps
module scg_gate_select (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire scg_pkg::scg_mode_t i_mode,
    input wire logic i_auto_gating_select,
    input wire logic [31:0] i_run_gate,
    input wire logic [31:0] i_sleep_gate,
    input wire logic [31:0] i_deep_gate,
    output logic [31:0] o_clk_en
);

    logic [31:0] clk_en_reg;
    logic [31:0] clk_en_next;

    always_comb begin
        clk_en_next = i_run_gate;
        // without auto gating the run vector rules in every mode
        if (i_auto_gating_select) begin
            case (i_mode)
                scg_pkg::SCG_RUN: begin
                    clk_en_next = i_run_gate;
                end
                scg_pkg::SCG_SLEEP: begin
                    clk_en_next = i_sleep_gate;
                end
                scg_pkg::SCG_DEEP_SLEEP: begin
                    clk_en_next = i_deep_gate;
                end
                default: begin
                    clk_en_next = i_run_gate;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clk_en_reg <= 32'h0000_0000;
        end else begin
            clk_en_reg <= clk_en_next & scg_pkg::SCG_GATE_WMASK;
        end
    end

    assign o_clk_en = clk_en_reg;

endmodule

//--- scg_sleep_gate.sv
// scg_sleep_gate: APB slave holding the sleep clock gating register,
// the applied clock enables per unit and bus fault flagging for
// accesses to units whose clock is off.
// assumes run and deep-sleep gate vectors, the auto gating select bit
// and the power mode levels come from system control logic on i_clk_sys.
//
// Notes on behaviour
// - each writable bit enables one unit's clock during sleep.
// - access to a unit whose clock is off gets a bus fault.
// - the sleep gate register resets to all zero, all units off.
// - run vector applies running, sleep vector in sleep, deep vector in deep.
// - sleep vectors take over only with auto gating select set.
// - bits 25 and 24 gate comparators b and a, read/write.
// - bits 19 to 16 gate timers d, c, b, a, read/write.
// - bits 14 and 12 gate two-wire units b and a, read/write.
// - bits 5 and 4 gate sync serial units b and a, read/write.
// - bits 2, 1, 0 gate async serial units c, b, a, read/write.
// - reserved bits read zero and ignore writes.
// - register sits at offset 0x114 from base 0x400FE000.
`timescale 1ns/10ps
module scg_sleep_gate #(
    parameter int FAULT_CNT_W = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // system control context
    input wire logic i_auto_gating_select,
    input wire logic i_sleep_now,
    input wire logic i_deep_sleep_now,
    input wire logic [31:0] i_run_clock_gate_1,
    input wire logic [31:0] i_deep_sleep_clock_gate_1,
    // peripheral access check
    input wire logic i_periph_access,
    input wire logic [4:0] i_periph_bit,
    output logic o_periph_fault,
    // applied clock enables, one per gate bit position
    output logic [31:0] o_clk_en
);

    generate
        if (FAULT_CNT_W < 1 || FAULT_CNT_W > scg_pkg::SCG_FLT_CNT_MAX_W) begin : g_chk
            $error("FAULT_CNT_W must be 1 to 16");
        end
    endgenerate

    // the writable mask has to name exactly the unit gate positions, or
    // a reserved lane would get a flop and a unit would lose its gate
    localparam logic [31:0] UNIT_MASK =
        (32'h0000_0001 << scg_pkg::SCG_COMPARATOR_B_BIT) |
        (32'h0000_0001 << scg_pkg::SCG_COMPARATOR_A_BIT) |
        (32'h0000_0001 << scg_pkg::SCG_GP_TIMER_D_BIT) |
        (32'h0000_0001 << scg_pkg::SCG_GP_TIMER_C_BIT) |
        (32'h0000_0001 << scg_pkg::SCG_GP_TIMER_B_BIT) |
        (32'h0000_0001 << scg_pkg::SCG_GP_TIMER_A_BIT) |
        (32'h0000_0001 << scg_pkg::SCG_TWO_WIRE_B_BIT) |
        (32'h0000_0001 << scg_pkg::SCG_TWO_WIRE_A_BIT) |
        (32'h0000_0001 << scg_pkg::SCG_SYNC_SERIAL_B_BIT) |
        (32'h0000_0001 << scg_pkg::SCG_SYNC_SERIAL_A_BIT) |
        (32'h0000_0001 << scg_pkg::SCG_ASYNC_SERIAL_C_BIT) |
        (32'h0000_0001 << scg_pkg::SCG_ASYNC_SERIAL_B_BIT) |
        (32'h0000_0001 << scg_pkg::SCG_ASYNC_SERIAL_A_BIT);

    // each check guards a field layout or decode that the logic relies on
    generate
        if (UNIT_MASK != scg_pkg::SCG_GATE_WMASK) begin : g_mask_chk
            $error("gate mask does not match the unit positions");
        end
        if (scg_pkg::SCG_FLT_STICKY_BIT >= scg_pkg::SCG_FLT_UNIT_LSB) begin : g_flag_chk
            $error("fault flag overlaps the unit field");
        end
        if (scg_pkg::SCG_FLT_UNIT_LSB + 5 > scg_pkg::SCG_FLT_CNT_LSB) begin : g_unit_chk
            $error("fault unit field overlaps the fault count");
        end
        if (scg_pkg::SCG_FLT_CNT_LSB + FAULT_CNT_W > 32) begin : g_cnt_chk
            $error("fault count runs past bit 31");
        end
        if (scg_pkg::SCG_MODE_AUTO_BIT < 2 || scg_pkg::SCG_MODE_DIFF_BIT < 2 ||
            scg_pkg::SCG_MODE_AUTO_BIT == scg_pkg::SCG_MODE_DIFF_BIT) begin : g_mode_chk
            $error("gate mode fields overlap");
        end
        // the decode compares only the upper twenty bits of the base address
        if (scg_pkg::SCG_BASE_ADDR[11:0] != 12'h000) begin : g_base_chk
            $error("base address must sit on a 4 KiB boundary");
        end
    endgenerate

    logic [31:0] sleep_gate_reg;
    logic [31:0] prdata_reg;
    logic fault_sticky_reg;
    logic [4:0] fault_unit_reg;
    logic [FAULT_CNT_W-1:0] fault_cnt_reg;
    scg_pkg::scg_mode_t mode_reg;
    scg_pkg::scg_mode_t mode_next;

    logic [31:0] clk_en;
    logic [31:0] run_gate;
    logic [31:0] deep_gate;
    logic [31:0] byte_mask;
    logic [31:0] rd_data;
    logic blk_hit;
    logic hit_sleep;
    logic hit_status;
    logic hit_mode;
    logic hit_fault;
    logic mapped;
    logic setup_rd;
    logic wr_done;
    logic fault_evt;
    logic fault_clr;
    logic [31:0] fault_word;
    logic [31:0] mode_word;

    // address decode against the full system control address
    assign blk_hit = (i_paddr[31:12] == scg_pkg::SCG_BASE_ADDR[31:12]) &&
                     (i_paddr[1:0] == 2'h0);
    assign hit_sleep = blk_hit && (i_paddr[11:0] == scg_pkg::SCG_SLEEP_GATE_OFS);
    assign hit_status = blk_hit && (i_paddr[11:0] == scg_pkg::SCG_GATE_STATUS_OFS);
    assign hit_mode = blk_hit && (i_paddr[11:0] == scg_pkg::SCG_GATE_MODE_OFS);
    assign hit_fault = blk_hit && (i_paddr[11:0] == scg_pkg::SCG_FAULT_STATUS_OFS);
    assign mapped = hit_sleep || hit_status || hit_mode || hit_fault;

    // zero wait states: the access phase always completes in one cycle
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped;

    assign setup_rd = i_psel && !i_penable && !i_pwrite;
    assign wr_done = i_psel && i_penable && i_pwrite;

    always_comb begin
        byte_mask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
    end

    // sleep gate register; only the writable lanes get flops
    genvar b;
    generate
        for (b = 0; b < 32; b = b + 1) begin : g_gate
            if (scg_pkg::SCG_GATE_WMASK[b]) begin : g_rw
                always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
                    if (!i_rst_n) begin
                        sleep_gate_reg[b] <= scg_pkg::SCG_SLEEP_GATE_RST[b];
                    end else if (wr_done && hit_sleep && byte_mask[b]) begin
                        sleep_gate_reg[b] <= i_pwdata[b];
                    end
                end
            end else begin : g_rsvd
                assign sleep_gate_reg[b] = 1'b0;
            end
        end
    endgenerate

    // reserved positions of the companion vectors never enable a clock
    assign run_gate = i_run_clock_gate_1 & scg_pkg::SCG_GATE_WMASK;
    assign deep_gate = i_deep_sleep_clock_gate_1 & scg_pkg::SCG_GATE_WMASK;

    // power mode tracking; deep sleep outranks sleep if both are shown
    always_comb begin
        case (mode_reg)
            scg_pkg::SCG_RUN,
            scg_pkg::SCG_SLEEP,
            scg_pkg::SCG_DEEP_SLEEP: begin
                if (i_deep_sleep_now) begin
                    mode_next = scg_pkg::SCG_DEEP_SLEEP;
                end else if (i_sleep_now) begin
                    mode_next = scg_pkg::SCG_SLEEP;
                end else begin
                    mode_next = scg_pkg::SCG_RUN;
                end
            end
            default: begin
                mode_next = scg_pkg::SCG_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_reg <= scg_pkg::SCG_RUN;
        end else begin
            mode_reg <= mode_next;
        end
    end

    scg_gate_select u_gate_select (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_mode(mode_reg),
        .i_auto_gating_select(i_auto_gating_select),
        .i_run_gate(run_gate),
        .i_sleep_gate(sleep_gate_reg),
        .i_deep_gate(deep_gate),
        .o_clk_en(clk_en)
    );

    assign o_clk_en = clk_en;

    // bus fault for any access to a unit whose clock is currently off;
    // answered in the same cycle so the access never reaches the unit
    assign fault_evt = i_periph_access && !clk_en[i_periph_bit];
    assign o_periph_fault = fault_evt;

    assign fault_clr = wr_done && hit_fault && i_pstrb[0] &&
                       i_pwdata[scg_pkg::SCG_FLT_STICKY_BIT];

    // sticky fault flag: a new fault in the clearing cycle wins
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fault_sticky_reg <= 1'b0;
        end else if (fault_evt) begin
            fault_sticky_reg <= 1'b1;
        end else if (fault_clr) begin
            fault_sticky_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fault_unit_reg <= 5'h00;
        end else if (fault_evt) begin
            fault_unit_reg <= i_periph_bit;
        end
    end

    // saturating fault count; cleared with the sticky flag unless a
    // fault lands in that very cycle, which then counts as the first
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fault_cnt_reg <= '0;
        end else if (fault_clr && fault_evt) begin
            fault_cnt_reg <= FAULT_CNT_W'(1);
        end else if (fault_clr) begin
            fault_cnt_reg <= '0;
        end else if (fault_evt && !(&fault_cnt_reg)) begin
            fault_cnt_reg <= fault_cnt_reg + FAULT_CNT_W'(1);
        end
    end

    always_comb begin
        fault_word = 32'h0000_0000;
        fault_word[scg_pkg::SCG_FLT_STICKY_BIT] = fault_sticky_reg;
        fault_word[scg_pkg::SCG_FLT_UNIT_LSB +: 5] = fault_unit_reg;
        fault_word[scg_pkg::SCG_FLT_CNT_LSB +: FAULT_CNT_W] = fault_cnt_reg;
    end

    // mode word also flags a stored sleep vector not yet in force
    always_comb begin
        mode_word = 32'h0000_0000;
        mode_word[1:0] = mode_reg;
        mode_word[scg_pkg::SCG_MODE_AUTO_BIT] = i_auto_gating_select;
        mode_word[scg_pkg::SCG_MODE_DIFF_BIT] = (sleep_gate_reg != clk_en);
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit_sleep) begin
            rd_data = sleep_gate_reg;
        end else if (hit_status) begin
            rd_data = clk_en;
        end else if (hit_mode) begin
            rd_data = mode_word;
        end else if (hit_fault) begin
            rd_data = fault_word;
        end
    end

    // read data is captured in the setup phase and held through access
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_reg <= rd_data;
        end
    end

    assign o_prdata = prdata_reg;

endmodule

//--- scg_sleep_gate_checker.sv
// scg_sleep_gate_checker: concurrent checks on the sleep gate block ports.
// assumes one clock domain and binding onto scg_sleep_gate.
`timescale 1ns/10ps
module scg_sleep_gate_checker (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic i_auto_gating_select,
    input wire logic i_sleep_now,
    input wire logic i_deep_sleep_now,
    input wire logic [31:0] i_run_clock_gate_1,
    input wire logic [31:0] i_deep_sleep_clock_gate_1,
    input wire logic i_periph_access,
    input wire logic [4:0] i_periph_bit,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    input wire logic o_periph_fault,
    input wire logic [31:0] o_clk_en
);
    localparam logic [31:0] M = scg_pkg::SCG_GATE_WMASK;
    logic [1:0] up_cnt;
    logic acc;
    logic up;
    // selection checks wait until no sampled input predates reset release
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    assign up = (up_cnt == 2'h3);
    assign acc = i_psel && i_penable;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);
    a_fault_gated:
        assert property (i_periph_access |-> o_periph_fault == !o_clk_en[i_periph_bit])
        else $error("fault does not match clock enable");
    a_run_awake:
        assert property (up && !$past(i_sleep_now, 2) && !$past(i_deep_sleep_now, 2)
            |-> o_clk_en == ($past(i_run_clock_gate_1) & M)) else $error("run vector not applied");
    a_run_no_auto:
        assert property (up && !$past(i_auto_gating_select) && !$past(i_auto_gating_select, 2)
            |-> o_clk_en == ($past(i_run_clock_gate_1) & M)) else $error("auto off not run");
    a_deep_apply:
        assert property (up && $past(i_deep_sleep_now, 2) && $past(i_auto_gating_select)
            && $past(i_auto_gating_select, 2)
            |-> o_clk_en == ($past(i_deep_sleep_clock_gate_1) & M)) else $error("deep not applied");
    a_reserved_off:
        assert property ((o_clk_en & ~M) == 32'h0) else $error("reserved enable set");
    a_reset_off:
        assert property ($rose(i_rst_n) |-> o_clk_en == 32'h0) else $error("enables on at reset");
    a_slverr_phase:
        assert property (o_pslverr |-> acc) else $error("slverr outside access");
    a_misalign_err:
        assert property (acc && i_paddr[1:0] != 2'h0 |-> o_pslverr) else $error("misaligned ok");
    a_gate_addr_ok:
        assert property (acc && i_paddr == (scg_pkg::SCG_BASE_ADDR |
            {20'h0_0000, scg_pkg::SCG_SLEEP_GATE_OFS}) |-> !o_pslverr)
        else $error("gate register refused");
    a_fault_idle:
        assert property (!i_periph_access |-> !o_periph_fault) else $error("fault without access");
    a_err_rdata_zero:
        assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0) else $error("err data");
endmodule

bind scg_sleep_gate scg_sleep_gate_checker u_chk (.i_clk_sys, .i_rst_n, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_auto_gating_select, .i_sleep_now, .i_deep_sleep_now,
    .i_run_clock_gate_1, .i_deep_sleep_clock_gate_1, .i_periph_access, .i_periph_bit,
    .o_prdata, .o_pslverr, .o_periph_fault, .o_clk_en);

//--- scg_sleep_gate_bench.sv
// scg_sleep_gate_bench: self-checking bench for the sleep gate block.
// assumes a zero-wait APB slave and a 100 MHz system clock.
`timescale 1ns/10ps
module scg_sleep_gate_bench;
    localparam logic [31:0] M = scg_pkg::SCG_GATE_WMASK;
    localparam logic [31:0] B = scg_pkg::SCG_BASE_ADDR;
    localparam logic [31:0] G = B + {20'h0_0000, scg_pkg::SCG_SLEEP_GATE_OFS};
    localparam logic [31:0] ST = B + {20'h0_0000, scg_pkg::SCG_GATE_STATUS_OFS};
    localparam logic [31:0] MD = B + {20'h0_0000, scg_pkg::SCG_GATE_MODE_OFS};
    localparam logic [31:0] FS = B + {20'h0_0000, scg_pkg::SCG_FAULT_STATUS_OFS};
    logic i_clk_sys, i_rst_n, i_psel, i_penable, i_pwrite, i_auto_gating_select;
    logic i_sleep_now, i_deep_sleep_now, i_periph_access, o_pready, o_pslverr, o_periph_fault;
    logic [31:0] i_paddr, i_pwdata, o_prdata, i_run_clock_gate_1, i_deep_sleep_clock_gate_1;
    logic [31:0] o_clk_en, rd, s, r, d, x;
    logic [3:0] i_pstrb;
    logic [4:0] i_periph_bit;
    logic err;
    int error_cnt = 0;
    int checks = 0;
    scg_sleep_gate u_dut (.i_clk_sys, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_auto_gating_select,
        .i_sleep_now, .i_deep_sleep_now, .i_run_clock_gate_1, .i_deep_sleep_clock_gate_1,
        .i_periph_access, .i_periph_bit, .o_periph_fault, .o_clk_en);
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd,
        input logic [3:0] st);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= wd;
        i_pstrb <= st;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        chk("pready", 32'h1, {31'h0, o_pready});
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    function automatic logic [31:0] sel(input logic au, sl, dp);
        if (!au || (!sl && !dp)) return r & M;
        return (dp ? d : s) & M;
    endfunction
    // enables settle two edges after a mode change, then every unit is probed
    task automatic gate_chk(input logic [31:0] e);
        repeat (3) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk("clk_en", e, o_clk_en);
        for (int b = 0; b < 32; b++) begin
            @(posedge i_clk_sys);
            i_periph_access <= 1'b1;
            i_periph_bit <= b[4:0];
            @(negedge i_clk_sys);
            chk("periph fault", {31'h0, ~e[b]}, {31'h0, o_periph_fault});
        end
        @(posedge i_clk_sys);
        i_periph_access <= 1'b0;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        finish_test;
    end
    initial begin
        {i_psel, i_penable, i_pwrite, i_auto_gating_select} = 4'h0;
        {i_sleep_now, i_deep_sleep_now, i_periph_access} = 3'h0;
        {i_paddr, i_pwdata, i_pstrb, i_periph_bit} = 73'h0;
        i_rst_n = 1'b0;
        rd = $urandom(32'hF743);
        r = $urandom;
        d = $urandom;
        s = 32'h0;
        i_run_clock_gate_1 = r;
        i_deep_sleep_clock_gate_1 = d;
        repeat (4) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        apb(1'b0, G, 32'h0, 4'h0);
        chk("reset value", 32'h0, rd);
        gate_chk(sel(1'b0, 1'b0, 1'b0));
        $display("reset test done");
        for (int i = 0; i < 10; i++) begin
            s = (i == 0) ? 32'hFFFF_FFFF : $urandom;
            apb(1'b1, G, s, 4'hF);
            apb(1'b0, G, 32'h0, 4'h0);
            chk("sleep gate rw", s & M, rd);
        end
        apb(1'b1, G, 32'h0, 4'hD);
        apb(1'b0, G, 32'h0, 4'h0);
        chk("byte lanes", s & M & 32'h0000_FF00, rd);
        $display("register test done");
        apb(1'b1, G + 32'h1, 32'hFFFF_FFFF, 4'hF);
        chk("misaligned err", 32'h1, {31'h0, err});
        apb(1'b0, G + 32'h4, 32'h0, 4'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb(1'b0, G, 32'h0, 4'h0);
        chk("write ignored", s & M & 32'h0000_FF00, rd);
        $display("decode test done");
        s = $urandom;
        apb(1'b1, G, s, 4'hF);
        i_auto_gating_select <= 1'b1;
        gate_chk(sel(1'b1, 1'b0, 1'b0));
        for (int m = 1; m < 4; m++) begin
            i_sleep_now <= m[0];
            i_deep_sleep_now <= m[1];
            gate_chk(sel(1'b1, m[0], m[1]));
        end
        i_deep_sleep_now <= 1'b0;
        i_auto_gating_select <= 1'b0;
        gate_chk(sel(1'b0, 1'b1, 1'b0));
        $display("gating test done");
        @(posedge i_clk_sys);
        i_rst_n <= 1'b0;
        @(negedge i_clk_sys);
        chk("clk_en in reset", 32'h0, o_clk_en);
        @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        apb(1'b0, G, 32'h0, 4'h0);
        chk("value after reset", 32'h0, rd);
        $display("second reset test done");
        // read-modify-write keeps the reserved bits exactly as read
        apb(1'b1, G, rd | 32'h0000_0001, 4'hF);
        apb(1'b0, ST, 32'h0, 4'h0);
        chk("gate status", r & M, rd);
        x = {31'h0, (r & M) != 32'h1} << scg_pkg::SCG_MODE_DIFF_BIT;
        x = x | {30'h0, scg_pkg::SCG_SLEEP};
        apb(1'b0, MD, 32'h0, 4'h0);
        chk("gate mode", x, rd);
        // one access to a reserved, never clocked position
        @(posedge i_clk_sys);
        i_periph_access <= 1'b1;
        i_periph_bit <= 5'h03;
        @(posedge i_clk_sys);
        i_periph_access <= 1'b0;
        x = (32'h1 << scg_pkg::SCG_FLT_CNT_LSB) | (32'h3 << scg_pkg::SCG_FLT_UNIT_LSB);
        x = x | (32'h1 << scg_pkg::SCG_FLT_STICKY_BIT);
        apb(1'b0, FS, 32'h0, 4'h0);
        chk("fault status", x, rd);
        apb(1'b1, FS, 32'h1, 4'h1);
        apb(1'b0, FS, 32'h0, 4'h0);
        chk("fault cleared", 32'h3 << scg_pkg::SCG_FLT_UNIT_LSB, rd);
        $display("status test done");
        finish_test;
    end
endmodule
